// >>> rtl/t2t_write_and_responses.v
/*
 * type 2 tag command interpreter: block write with ack and error codes,
 * request and select answers, halt, and field-drop reset.
 * assumes a frame receiver that presents decoded bytes on link_data with a
 * strobe link_clk and a per-byte parity flag, all from another domain, and
 * an anticollision unit on clk that reports a full uid match.
 */
// Contract
// - write frame: a2h, block address, four data bytes, two crc bytes.
// - write with wrong payload length gets no reply at all.
// - parity or crc failure on write answers checksum code, memory untouched.
// - block address above 3fh answers invalid-argument code.
// - memory is read back after programming; mismatch answers write-failure code.
// - successful write answers four-bit acknowledge ah.
// - error codes: 0h invalid argument, 1h parity/crc, 5h write failure.
// - write reply starts 4163 us after frame end; poller waits 4734 us.
// - unknown command code gets no reply.
// - every error, answered or silent, returns to idle or halt.
// - error goes to halt if halted since power-up, else idle.
// - request or wake-up answers 44h 00h.
// - matching select answers 00h then fe 51h.
// - block 3 defaults to the capability container bytes.
// - block 4 defaults to an empty message and terminator.
// - block 3fh byte 2 defaults to 78h; custom source defaults to uid text; code uses the stand-in 3030h.
`timescale 1ns/1ns
`include "t2t_defs.vh"
module t2t_write_and_responses #(
	parameter        WRITE_DELAY_CYC = `WRITE_REPLY_US * (`CLK_KHZ / 1000),
	parameter        SHORT_DELAY_CYC = (`FDT_N_SHORT * `FDT_UNIT + `FDT_ADD_ONE)
	                                   * `CLK_KHZ / `FC_KHZ,
	parameter        PROG_CYCLES     = 64,
	parameter        FIFO_DEPTH      = 32,
	parameter [15:0] CUSTOM_SRC      = 16'h3030  // arbitrary stand-in for uid text
) (
	input  wire       clk,            // core clock, 250 mhz
	input  wire       rst,            // synchronous reset, active high
	input  wire       ce,             // clock enable, freezes all state when low
	input  wire       field_on,       // carrier present, from the analog front end
	input  wire       link_clk,       // byte strobe from the frame receiver
	input  wire       link_frame,     // high while a frame is received
	input  wire [7:0] link_data,      // received byte
	input  wire       link_perr,      // parity error on this byte
	input  wire       uid_match,      // select uid bits fully match
	input  wire       cell_fault,     // weak nvm cell
	output wire       tx_valid,       // reply word offered
	input  wire       tx_ready,       // modulator takes word
	output wire [7:0] tx_data,        // reply byte, or code in bits 3:0
	output wire       tx_short,       // this word is a four-bit frame
	output wire       tx_last,        // last word of the reply
	output reg  [4:0] protocol_state  // one-hot off, idle, ready, active, halt
);
	localparam S_OFF    = 5'b00001;
	localparam S_IDLE   = 5'b00010;
	localparam S_READY  = 5'b00100;
	localparam S_ACTIVE = 5'b01000;
	localparam S_HALT   = 5'b10000;
	localparam P_WAIT   = 4'b0001;
	localparam P_PROG   = 4'b0010;
	localparam P_PUSH   = 4'b0100;
	localparam P_HOLD   = 4'b1000;

	// ------------------------------------------------------------ pin sync
	reg  [11:0] s1_reg;
	reg  [11:0] s2_reg;
	reg  [11:0] s3_reg;
	reg  [11:0] filt_reg;
	wire [11:0] filt_next;
	wire [11:0] agree;

	assign agree     = ~(s2_reg ^ s3_reg);
	assign filt_next = (s2_reg & agree) | (filt_reg & ~agree);

	always @(posedge clk) begin
		if (rst) begin
			s1_reg   <= 12'h000;
			s2_reg   <= 12'h000;
			s3_reg   <= 12'h000;
			filt_reg <= 12'h000;
		end else if (ce) begin
			s1_reg   <= {field_on, link_frame, link_clk, link_perr, link_data};
			s2_reg   <= s1_reg;
			s3_reg   <= s2_reg;
			filt_reg <= filt_next;
		end
	end

	wire field_up   = filt_reg[11];
	wire frame_rise = filt_next[10] & ~filt_reg[10];
	wire frame_fall = ~filt_next[10] & filt_reg[10];
	wire byte_stb   = filt_next[9] & ~filt_reg[9] & filt_next[10];

	// ------------------------------------------------------------ frame rx
	function [15:0] crc_byte;
		input [15:0] crc_in;
		input [7:0]  data;
		integer      k;
		reg   [15:0] c;
		begin
			c = crc_in ^ {8'h00, data};
			for (k = 0; k < 8; k = k + 1)
				c = c[0] ? ((c >> 1) ^ `CRC_POLY) : (c >> 1);
			crc_byte = c;
		end
	endfunction

	reg  [7:0]  rx_mem [0:7];
	reg  [3:0]  cnt_reg;
	reg  [15:0] crc_reg;
	reg         perr_reg;
	reg         done_reg;

	always @(posedge clk) begin
		if (rst | ~field_up) begin
			cnt_reg  <= 4'h0;
			crc_reg  <= `CRC_INIT;
			perr_reg <= 1'b0;
			done_reg <= 1'b0;
		end else if (ce) begin
			done_reg <= frame_fall;
			if (frame_rise) begin
				cnt_reg  <= 4'h0;
				crc_reg  <= `CRC_INIT;
				perr_reg <= 1'b0;
			end else if (byte_stb) begin
				// count saturates one past a write frame so overlength shows
				if (cnt_reg < 4'h8)
					rx_mem[cnt_reg[2:0]] <= filt_next[7:0];
				if (cnt_reg != 4'h9)
					cnt_reg <= cnt_reg + 4'h1;
				crc_reg  <= crc_byte(crc_reg, filt_next[7:0]);
				perr_reg <= perr_reg | filt_next[8];
			end
		end
	end

	// ------------------------------------------------------------ decode
	wire [7:0]  cmd      = rx_mem[0];
	wire [7:0]  arg      = rx_mem[1];
	wire [5:0]  blk      = arg[5:0];
	wire        crc_ok   = (crc_reg == 16'h0000) & ~perr_reg;
	wire [15:0] lock_word;
	wire        is_req   = (cnt_reg == 4'h1) & (cmd == `CMD_REQA);
	wire        is_wup   = (cnt_reg == 4'h1) & (cmd == `CMD_WUPA);
	wire        is_sel   = (cnt_reg > 4'h2) & ((cmd == `CMD_SEL_CL1) | (cmd == `CMD_SEL_CL2))
	                       & (arg == `CMD_SEL_NVB) & crc_ok & uid_match;
	wire        is_halt  = (cnt_reg == `HALT_FRAME_LEN) & (cmd == `CMD_HALT)
	                       & (arg == 8'h00) & crc_ok;
	wire        is_write = (cnt_reg != 4'h0) & (cmd == `CMD_WRITE);
	wire        is_read  = (cnt_reg != 4'h0) & (cmd == `CMD_READ);
	// system blocks 0 and 1 are fixed; lock block 2 always writable
	wire        ro_blk   = (blk < `LOCK_BLOCK) | ((blk > `LOCK_BLOCK)
	                       & (blk <= `LAST_STATIC_LOCKED) & lock_word[blk[3:0]]);

	// ------------------------------------------------------------ control
	reg  [3:0]  proc_reg;
	reg         halted_reg;
	reg  [1:0]  len_reg;
	reg  [1:0]  idx_reg;
	reg  [7:0]  b0_reg;
	reg  [7:0]  b1_reg;
	reg  [7:0]  b2_reg;
	reg         short_reg;
	reg  [4:0]  after_reg;
	reg  [20:0] dly_reg;
	reg         rel_reg;
	reg         prog_start;
	reg  [31:0] prog_data;
	wire        wr_done;
	wire        wr_ok;
	wire [4:0]  err_state = halted_reg ? S_HALT : S_IDLE;
	wire        fifo_in_ready;
	wire        fifo_out_valid;
	wire [9:0]  fifo_out;
	wire [7:0]  push_byte = (idx_reg == 2'h0) ? b0_reg :
	                        (idx_reg == 2'h1) ? b1_reg : b2_reg;
	wire        push_last = (idx_reg == len_reg);
	wire        push      = proc_reg[2] & fifo_in_ready;

	assign tx_valid = fifo_out_valid & rel_reg;
	assign tx_data  = fifo_out[7:0];
	assign tx_short = fifo_out[8];
	assign tx_last  = fifo_out[9];

	// one-, two- or three-word reply, sent after the delay runs out
	task reply;
		input [1:0] n;
		input [7:0] x0;
		input [7:0] x1;
		input [7:0] x2;
		input       sh;
		input [4:0] nxt;
		begin
			len_reg   <= n;
			b0_reg    <= x0;
			b1_reg    <= x1;
			b2_reg    <= x2;
			short_reg <= sh;
			after_reg <= nxt;
			idx_reg   <= 2'h0;
			proc_reg  <= P_PUSH;
		end
	endtask

	always @(posedge clk) begin
		if (rst | ~field_up) begin
			protocol_state <= S_OFF;
			halted_reg     <= 1'b0;
			proc_reg       <= P_WAIT;
			len_reg        <= 2'h0;
			idx_reg        <= 2'h0;
			b0_reg         <= 8'h00;
			b1_reg         <= 8'h00;
			b2_reg         <= 8'h00;
			short_reg      <= 1'b0;
			after_reg      <= S_IDLE;
			dly_reg        <= 21'h000000;
			rel_reg        <= 1'b0;
			prog_start     <= 1'b0;
			prog_data      <= 32'h00000000;
		end else if (ce) begin
			prog_start <= 1'b0;
			if (dly_reg != 21'h000000)
				dly_reg <= dly_reg - 21'h000001;
			case (proc_reg)
			P_WAIT: begin
				if (protocol_state == S_OFF)
					protocol_state <= S_IDLE;
				else if (done_reg) begin
					dly_reg <= SHORT_DELAY_CYC[20:0];
					case (protocol_state)
					S_IDLE, S_HALT: begin
						if (is_wup | (is_req & (protocol_state == S_IDLE)))
							reply(2'h1, `ATQA_BYTE0, `ATQA_BYTE1, 8'h00, 1'b0, S_READY);
					end
					S_READY: begin
						if (is_sel)
							reply(2'h2, `SAK_BYTE, `SAK_CRC_LO, `SAK_CRC_HI, 1'b0, S_ACTIVE);
						else
							protocol_state <= err_state;
					end
					S_ACTIVE: begin
						dly_reg <= WRITE_DELAY_CYC[20:0];
						if (is_halt) begin
							protocol_state <= S_HALT;
							halted_reg     <= 1'b1;
						end else if (is_write) begin
							if (cnt_reg != `WRITE_FRAME_LEN)
								protocol_state <= err_state;
							else if (~crc_ok)
								reply(2'h0, {4'h0, `ERR_PARITY_CHECKSUM}, 8'h00, 8'h00,
								      1'b1, err_state);
							else if ((arg > `LAST_BLOCK) | ro_blk)
								reply(2'h0, {4'h0, `ERR_INVALID_ARGUMENT}, 8'h00, 8'h00,
								      1'b1, err_state);
							else begin
								// only a fully checked frame reaches the cells
								prog_start <= 1'b1;
								prog_data  <= {rx_mem[5], rx_mem[4], rx_mem[3], rx_mem[2]};
								proc_reg   <= P_PROG;
							end
						end else if (~is_read)
							// reads belong to another unit and are left alone here
							protocol_state <= err_state;
					end
					default: protocol_state <= err_state;
					endcase
				end
			end
			P_PROG: begin
				if (wr_done) begin
					if (wr_ok)
						reply(2'h0, {4'h0, `ACK_CODE}, 8'h00, 8'h00, 1'b1, S_ACTIVE);
					else
						reply(2'h0, {4'h0, `ERR_NVM_WRITE}, 8'h00, 8'h00,
						      1'b1, err_state);
				end
			end
			P_PUSH: begin
				if (push) begin
					idx_reg <= idx_reg + 2'h1;
					if (push_last)
						proc_reg <= P_HOLD;
				end
			end
			P_HOLD: begin
				// the reply is held back until the frame delay has passed
				if (dly_reg == 21'h000000)
					rel_reg <= 1'b1;
				if (tx_valid & tx_ready & tx_last) begin
					rel_reg        <= 1'b0;
					protocol_state <= after_reg;
					proc_reg       <= P_WAIT;
				end
			end
			default: proc_reg <= P_WAIT;
			endcase
		end
	end

	nvm_blocks #(
		.BLOCKS      (64),
		.PROG_CYCLES (PROG_CYCLES),
		.CAP_SIZE    (`CAP_SIZE_BYTE),
		.CUSTOM_SRC  (CUSTOM_SRC)
	) u_nvm (
		.clk        (clk),
		.rst        (rst),
		.ce         (ce),
		.wr_start   (prog_start),
		.wr_addr    (blk),
		.wr_data    (prog_data),
		.cell_fault (cell_fault),
		.wr_done    (wr_done),
		.wr_ok      (wr_ok),
		.lock_word  (lock_word)
	);

	resp_fifo #(
		.WIDTH (10),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk       (clk),
		.rst       (rst),
		.ce        (ce),
		.in_data   ({push_last, short_reg, push_byte}),
		.in_valid  (proc_reg[2]),
		.in_ready  (fifo_in_ready),
		.out_data  (fifo_out),
		.out_valid (fifo_out_valid),
		.out_ready (tx_ready & rel_reg)
	);
endmodule

// >>> rtl/t2t_defs.vh
/*
 * shared constants of the type 2 tag write and reply logic: command codes,
 * reply codes, factory image bytes, frame lengths and timing figures.
 * assumes inclusion by bare name from the rtl files.
 */
`ifndef T2T_DEFS_VH
`define T2T_DEFS_VH

`define CMD_WRITE             8'ha2
`define CMD_REQA              8'h26
`define CMD_WUPA              8'h52
`define CMD_SEL_CL1           8'h93
`define CMD_SEL_CL2           8'h95
`define CMD_SEL_NVB           8'h70
`define CMD_HALT              8'h50
`define CMD_READ              8'h30
`define WRITE_FRAME_LEN       4'h8
`define HALT_FRAME_LEN        4'h4

`define ACK_CODE              4'ha
`define ERR_INVALID_ARGUMENT  4'h0
`define ERR_PARITY_CHECKSUM   4'h1
`define ERR_NVM_WRITE         4'h5

`define ATQA_BYTE0            8'h44
`define ATQA_BYTE1            8'h00
`define SAK_BYTE              8'h00
`define SAK_CRC_LO            8'hfe
`define SAK_CRC_HI            8'h51

`define LAST_BLOCK            8'h3f
`define LOCK_BLOCK            6'h02
`define CC_BLOCK              6'h03
`define TLV_BLOCK             6'h04
`define AUG_BLOCK             6'h3f
`define LAST_STATIC_LOCKED    6'h0f
`define CAP_MAGIC_BYTE        8'he1
`define CAP_VERSION_BYTE      8'h10
`define CAP_SIZE_BYTE         8'h14
`define CAP_ACCESS_BYTE       8'h00
`define TLV_DEFAULT_WORD      32'h00fe0003
`define AUG_SEPARATOR_BYTE    8'h78

`define CRC_INIT              16'h6363
`define CRC_POLY              16'h8408

`define CLK_KHZ               250000
`define FC_KHZ                13560
`define WRITE_REPLY_US        4163
`define WRITE_TIMEOUT_US      4734
`define FDT_N_WRITE           443
`define FDT_N_MAX             501
`define FDT_N_SHORT           9
`define FDT_ADD_ONE           84
`define FDT_UNIT              128

`endif

// >>> rtl/resp_fifo.v
/*
 * reply byte fifo with valid and ready on both sides.
 * assumes a single clock; the drain side may stall and so fill it.
 */
`timescale 1ns/1ns
module resp_fifo #(
	parameter WIDTH = 10,
	parameter DEPTH = 32
) (
	input  wire             clk,       // core clock
	input  wire             rst,       // synchronous reset
	input  wire             ce,        // clock enable
	input  wire [WIDTH-1:0] in_data,   // word to store
	input  wire             in_valid,  // word offered
	output wire             in_ready,  // room available
	output wire [WIDTH-1:0] out_data,  // oldest word
	output wire             out_valid, // fifo not empty
	input  wire             out_ready  // drain takes word
);
	localparam AW = $clog2(DEPTH);

	reg  [WIDTH-1:0] mem [0:DEPTH-1];
	reg  [AW-1:0]    wr_reg;
	reg  [AW-1:0]    rd_reg;
	reg  [AW:0]      cnt_reg;
	wire             push;
	wire             pop;

	assign in_ready  = (cnt_reg != DEPTH[AW:0]);
	assign out_valid = (cnt_reg != {(AW+1){1'b0}});
	assign out_data  = mem[rd_reg];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	always @(posedge clk) begin
		if (rst) begin
			wr_reg  <= {AW{1'b0}};
			rd_reg  <= {AW{1'b0}};
			cnt_reg <= {(AW+1){1'b0}};
		end else if (ce) begin
			if (push) begin
				mem[wr_reg] <= in_data;
				wr_reg      <= wr_reg + 1'b1;
			end
			if (pop)
				rd_reg <= rd_reg + 1'b1;
			if (push & ~pop)
				cnt_reg <= cnt_reg + 1'b1;
			else if (pop & ~push)
				cnt_reg <= cnt_reg - 1'b1;
		end
	end
endmodule

// >>> rtl/nvm_blocks.v
/*
 * nonvolatile block store: 4-byte blocks, factory image, timed programming
 * followed by a read-back check. assumes a single clock; the array keeps
 * its content through reset, as the cells would through a field drop.
 */
`timescale 1ns/1ns
`include "t2t_defs.vh"
module nvm_blocks #(
	parameter        BLOCKS      = 64,
	parameter        PROG_CYCLES = 64,
	parameter [7:0]  CAP_SIZE    = `CAP_SIZE_BYTE,
	parameter [15:0] CUSTOM_SRC  = 16'h3030  // arbitrary stand-in for uid text
) (
	input  wire        clk,        // core clock
	input  wire        rst,        // synchronous reset
	input  wire        ce,         // clock enable
	input  wire        wr_start,   // begin programming, one cycle
	input  wire [5:0]  wr_addr,    // block to program
	input  wire [31:0] wr_data,    // byte 0 in bits 7:0
	input  wire        cell_fault, // weak cell, corrupts the stored word
	output reg         wr_done,    // programming and check finished, pulse
	output reg         wr_ok,      // check result, valid with wr_done
	output wire [15:0] lock_word   // static lock bytes of the lock block
);
	reg  [31:0] mem [0:BLOCKS-1];
	reg  [15:0] tmr_reg;
	reg         busy_reg;
	reg         chk_reg;
	reg  [5:0]  adr_reg;
	reg  [31:0] dat_reg;
	integer     i;

	// factory image; the augmented custom source sits in bytes 0 and 1
	initial begin
		for (i = 0; i < BLOCKS; i = i + 1)
			mem[i] = 32'h00000000;
		mem[`CC_BLOCK]  = {`CAP_ACCESS_BYTE, CAP_SIZE, `CAP_VERSION_BYTE, `CAP_MAGIC_BYTE};
		mem[`TLV_BLOCK] = `TLV_DEFAULT_WORD;
		mem[`AUG_BLOCK] = {8'h00, `AUG_SEPARATOR_BYTE, CUSTOM_SRC};
	end

	assign lock_word = mem[`LOCK_BLOCK][31:16];

	always @(posedge clk) begin
		if (rst) begin
			tmr_reg  <= 16'h0000;
			busy_reg <= 1'b0;
			chk_reg  <= 1'b0;
			adr_reg  <= 6'h00;
			dat_reg  <= 32'h00000000;
			wr_done  <= 1'b0;
			wr_ok    <= 1'b0;
		end else if (ce) begin
			wr_done <= 1'b0;
			chk_reg <= 1'b0;
			if (wr_start & ~busy_reg) begin
				busy_reg <= 1'b1;
				tmr_reg  <= PROG_CYCLES[15:0];
				adr_reg  <= wr_addr;
				dat_reg  <= wr_data;
			end else if (busy_reg) begin
				if (tmr_reg != 16'h0000) begin
					tmr_reg <= tmr_reg - 16'h0001;
				end else begin
					mem[adr_reg] <= dat_reg ^ {31'h00000000, cell_fault};
					busy_reg     <= 1'b0;
					chk_reg      <= 1'b1;
				end
			end
			// read back what the cells hold, not what was asked for
			if (chk_reg) begin
				wr_done <= 1'b1;
				wr_ok   <= (mem[adr_reg] == dat_reg);
			end
		end
	end
endmodule

// >>> bench/t2t_props_properties.sv
/*
 * checker for the tag command interpreter: reply codes, reply timing,
 * handshake hold and state after errors. assumes it is bound to the top.
 */
`timescale 1ns/1ns
module t2t_props #(
	parameter int WRITE_DELAY_CYC = 1040750,
	parameter int SHORT_DELAY_CYC = 22787
) (
	input wire logic       clk,            // core clock
	input wire logic       rst,            // synchronous reset
	input wire logic       field_on,       // carrier present
	input wire logic       link_frame,     // frame in progress
	input wire logic       tx_valid,       // reply word offered
	input wire logic       tx_ready,       // reply word taken
	input wire logic [7:0] tx_data,        // reply byte or code
	input wire logic       tx_short,       // four-bit frame
	input wire logic       tx_last,        // last reply word
	input wire logic [4:0] protocol_state  // one-hot state
);
	int gap_cnt;
	int off_cnt;

	// saturating so a long idle run cannot wrap into a false early reply
	always @(posedge clk)
		if (rst || link_frame)
			gap_cnt <= 0;
		else if (gap_cnt < 2000000)
			gap_cnt <= gap_cnt + 1;

	always @(posedge clk)
		if (rst || field_on)
			off_cnt <= 0;
		else if (off_cnt < 100)
			off_cnt <= off_cnt + 1;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	reset_quiet_a: assert property (disable iff (1'b0) rst |=> !tx_valid && protocol_state == 5'h01)
		else $error("outputs active after reset");
	state_onehot_a: assert property ($onehot(protocol_state))
		else $error("state not one-hot");
	code_set_a: assert property (tx_valid && tx_short |-> tx_last && tx_data inside {8'h0a, 8'h00, 8'h01, 8'h05})
		else $error("bad short reply code");
	ack_state_a: assert property (tx_valid && tx_short && tx_data == 8'h0a |-> protocol_state == 5'h08)
		else $error("ack outside active state");
	nack_leave_a: assert property (tx_valid && tx_ready && tx_short && tx_data != 8'h0a
		|-> ##[1:8] (protocol_state == 5'h02 || protocol_state == 5'h10))
		else $error("error reply did not end in idle or halt");
	write_delay_a: assert property ($rose(tx_valid) && tx_short |-> gap_cnt >= WRITE_DELAY_CYC)
		else $error("write reply too early");
	short_delay_a: assert property ($rose(tx_valid) |-> gap_cnt >= SHORT_DELAY_CYC)
		else $error("reply too early");
	word_stand_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data)
		&& $stable(tx_last) && $stable(tx_short))
		else $error("reply word dropped before taken");
	field_off_a: assert property (off_cnt >= 8 |-> protocol_state == 5'h01)
		else $error("state kept without field");
endmodule

bind t2t_write_and_responses t2t_props #(
	.WRITE_DELAY_CYC(WRITE_DELAY_CYC),
	.SHORT_DELAY_CYC(SHORT_DELAY_CYC)
) props_i (.clk, .rst, .field_on, .link_frame, .tx_valid, .tx_ready, .tx_data, .tx_short,
	.tx_last, .protocol_state);

// >>> bench/reader_model.sv
/*
 * poller model: sends byte frames with crc over the link strobe and takes
 * reply words. assumes tasks are called from the bench on clk.
 */
`timescale 1ns/1ns
module reader_model (
	input  wire logic       clk,        // core clock
	output logic            link_clk,   // byte strobe, 80 ns in frames
	output logic            link_frame, // frame in progress
	output logic [7:0]      link_data,  // byte on the line
	output logic            link_perr,  // parity error flag
	input  wire logic       tx_valid,   // reply word offered
	input  wire logic [7:0] tx_data,    // reply byte
	input  wire logic       tx_short,   // four-bit frame
	input  wire logic       tx_last,    // last word
	output logic            tx_ready    // word taken
);
	initial begin
		link_clk = 1'b0;
		link_frame = 1'b0;
		link_data = 8'h00;
		link_perr = 1'b0;
		tx_ready = 1'b0;
	end

	function automatic logic [15:0] step(input logic [15:0] c, input logic [7:0] d);
		int k;
		c = c ^ {8'h00, d};
		for (k = 0; k < 8; k++)
			c = c[0] ? (c >> 1) ^ 16'h8408 : c >> 1;
		return c;
	endfunction

	// 20 clk per byte: data settles 5 clk before the strobe and holds after it
	task automatic put_byte(input logic [7:0] v, input logic p);
		link_data <= v;
		link_perr <= p;
		repeat (5) @(posedge clk);
		link_clk <= 1'b1;
		repeat (10) @(posedge clk);
		link_clk <= 1'b0;
		repeat (5) @(posedge clk);
	endtask

	task automatic send(input logic [7:0] b [8], input int n, input bit crc_on,
	                    input bit crc_bad, input int perr_at);
		logic [15:0] c;
		int          i;
		c = 16'h6363;
		for (i = 0; i < n; i++)
			c = step(c, b[i]);
		c = c ^ {15'h0000, crc_bad};
		@(posedge clk);
		link_frame <= 1'b1;
		repeat (5) @(posedge clk);
		for (i = 0; i < n; i++)
			put_byte(b[i], i == perr_at);
		if (crc_on) begin
			put_byte(c[7:0], 1'b0);
			put_byte(c[15:8], 1'b0);
		end
		link_frame <= 1'b0;
		link_data <= ~link_data; // released line must not show the last byte
	endtask

	task automatic rx(input int stall, output logic [7:0] d, output logic s, output logic l,
	                  output int gap);
		gap = 0;
		do begin
			@(negedge clk);
			gap++;
		end while (tx_valid !== 1'b1 && gap < 5000);
		d = tx_data;
		s = tx_short;
		l = tx_last;
		repeat (stall) @(posedge clk);
		@(posedge clk);
		tx_ready <= 1'b1;
		@(posedge clk);
		tx_ready <= 1'b0;
	endtask
endmodule

// >>> bench/testbench.sv
/*
 * testbench for the tag command interpreter: table of write cases, then
 * halt, field drop and reset cases. assumes the reader model and checker.
 */
`timescale 1ns/1ns
module testbench;
	localparam int WD = 200;
	localparam int SD = 50;
	typedef struct packed {
		logic [7:0]  cmd;
		logic [7:0]  addr;
		logic [31:0] data;
		logic [3:0]  n;
		logic [1:0]  bad;
		logic        fault;
		logic [7:0]  code;
		logic [4:0]  st;
	} row_t;
	logic       clk, rst, ce, field_on, uid_match, cell_fault;
	logic       link_clk, link_frame, link_perr, tx_valid, tx_ready, tx_short, tx_last;
	logic [7:0] link_data, tx_data;
	logic [4:0] protocol_state;
	int         failures, num_checks, r, stall_cyc;
	row_t       rows [11] = '{
		'{8'ha2, 8'h05, 32'h44332211, 4'h6, 2'h0, 1'b0, 8'h0a, 5'h08},
		'{8'ha2, 8'h40, 32'h00000000, 4'h6, 2'h0, 1'b0, 8'h00, 5'h02},
		'{8'ha2, 8'h00, 32'h00000000, 4'h6, 2'h0, 1'b0, 8'h00, 5'h02},
		'{8'ha2, 8'h02, 32'h00080000, 4'h6, 2'h0, 1'b0, 8'h0a, 5'h08},
		'{8'ha2, 8'h03, 32'h00000000, 4'h6, 2'h0, 1'b0, 8'h00, 5'h02},
		'{8'ha2, 8'h3f, 32'h00000000, 4'h6, 2'h1, 1'b0, 8'h01, 5'h02},
		'{8'ha2, 8'h05, 32'h00000000, 4'h6, 2'h2, 1'b0, 8'h01, 5'h02},
		'{8'ha2, 8'h3f, 32'h00000000, 4'h6, 2'h0, 1'b1, 8'h05, 5'h02},
		'{8'ha2, 8'h05, 32'h00000000, 4'h5, 2'h0, 1'b0, 8'hff, 5'h02},
		'{8'h77, 8'h05, 32'h00000000, 4'h6, 2'h0, 1'b0, 8'hff, 5'h02},
		'{8'ha2, 8'h3f, 32'h78000000, 4'h6, 2'h0, 1'b0, 8'h0a, 5'h08}
	};

	t2t_write_and_responses #(.WRITE_DELAY_CYC(WD), .SHORT_DELAY_CYC(SD), .PROG_CYCLES(8),
		.FIFO_DEPTH(32)) dut (.clk, .rst, .ce, .field_on, .link_clk, .link_frame, .link_data,
		.link_perr, .uid_match, .cell_fault, .tx_valid, .tx_ready, .tx_data, .tx_short,
		.tx_last, .protocol_state);
	reader_model reader (.clk, .link_clk, .link_frame, .link_data, .link_perr, .tx_valid,
		.tx_data, .tx_short, .tx_last, .tx_ready);

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic summarize();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		num_checks++;
		if (got !== exp) begin
			$display("unexpected %s expected %h seen %h", name, exp, got);
			failures++;
		end
	endtask

	task automatic settle_state(input logic [4:0] st);
		repeat (8) @(negedge clk);
		chk("protocol state", {3'h0, st}, {3'h0, protocol_state});
	endtask

	task automatic wait_idle();
		int i;
		i = 0;
		while (protocol_state !== 5'h02 && i < 100) begin
			@(negedge clk);
			i++;
		end
		chk("idle after start", 8'h02, {3'h0, protocol_state});
	endtask

	task automatic expect_reply(input int n, input logic [23:0] w, input logic sh,
	                            input int lo, input int hi);
		logic [7:0] d;
		logic       s, l;
		int         g, i;
		for (i = 0; i < n; i++) begin
			reader.rx(stall_cyc, d, s, l, g);
			if (g >= 5000) begin
				chk("reply timeout", 8'h00, 8'h01);
				summarize();
			end
			chk("reply word", w[8*i +: 8], d);
			chk("short flag", {7'h00, sh}, {7'h00, s});
			chk("last flag", {7'h00, i == n - 1}, {7'h00, l});
			if (i == 0)
				chk("reply delay in range", 8'h01, {7'h00, g >= lo && g <= hi});
		end
	endtask

	task automatic silent(input int cyc);
		logic seen;
		seen = 1'b0;
		repeat (cyc) @(negedge clk)
			if (tx_valid === 1'b1)
				seen = 1'b1;
		chk("reply seen", 8'h00, {7'h00, seen});
	endtask

	task automatic activate(input logic [7:0] req);
		logic [7:0] fb [8];
		fb = '{req, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
		reader.send(fb, 1, 1'b0, 1'b0, -1);
		expect_reply(2, 24'h000044, 1'b0, SD, SD + 60);
		settle_state(5'h04);
		fb = '{8'h93, 8'h70, 8'h11, 8'h22, 8'h33, 8'h44, 8'h44, 8'h00};
		reader.send(fb, 7, 1'b1, 1'b0, -1);
		expect_reply(3, 24'h51fe00, 1'b0, SD, SD + 60);
		settle_state(5'h08);
	endtask

	task automatic write_case(input row_t w);
		logic [7:0] fb [8];
		fb = '{w.cmd, w.addr, w.data[7:0], w.data[15:8], w.data[23:16], w.data[31:24],
		       8'h00, 8'h00};
		@(posedge clk);
		cell_fault <= w.fault;
		reader.send(fb, int'(w.n), w.n != 4'h1, w.bad == 2'h1, w.bad == 2'h2 ? 3 : -1);
		if (w.code === 8'hff)
			silent(WD + 100);
		else
			expect_reply(1, {16'h0000, w.code}, 1'b1, WD, WD + 60);
		@(posedge clk);
		cell_fault <= 1'b0;
		settle_state(w.st);
	endtask

	initial begin
		rst = 1'b1;
		ce = 1'b1;
		field_on = 1'b1;
		uid_match = 1'b1;
		cell_fault = 1'b0;
		stall_cyc = 0;
		repeat (6) @(posedge clk);
		chk("state in reset", 8'h01, {3'h0, protocol_state});
		chk("valid in reset", 8'h00, {7'h00, tx_valid});
		rst <= 1'b0;
		wait_idle();
		chk("cap magic", 8'he1, dut.u_nvm.mem[3][7:0]);
		chk("cap version", 8'h10, dut.u_nvm.mem[3][15:8]);
		chk("tlv type", 8'h03, dut.u_nvm.mem[4][7:0]);
		chk("tlv terminator", 8'hfe, dut.u_nvm.mem[4][23:16]);
		chk("separator", 8'h78, dut.u_nvm.mem[63][23:16]);
		$display("reset test done");
		for (r = 0; r < 11; r++) begin
			if (protocol_state !== 5'h08)
				activate(8'h26);
			write_case(rows[r]);
			$display("row %0d done", r);
		end
		chk("locked block kept", 8'he1, dut.u_nvm.mem[3][7:0]);
		chk("written block kept", 8'h11, dut.u_nvm.mem[5][7:0]);
		write_case('{8'h50, 8'h00, 32'h0, 4'h2, 2'h0, 1'b0, 8'hff, 5'h10});
		write_case('{8'h26, 8'h00, 32'h0, 4'h1, 2'h0, 1'b0, 8'hff, 5'h10});
		activate(8'h52);
		stall_cyc = 6;
		write_case('{8'ha2, 8'h05, 32'h0, 4'h6, 2'h1, 1'b0, 8'h01, 5'h10});
		stall_cyc = 0;
		$display("halt test done");
		@(posedge clk);
		field_on <= 1'b0;
		settle_state(5'h01);
		@(posedge clk);
		field_on <= 1'b1;
		wait_idle();
		activate(8'h26);
		write_case('{8'ha2, 8'h05, 32'h0, 4'h6, 2'h1, 1'b0, 8'h01, 5'h02});
		$display("field drop test done");
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		chk("state in reset", 8'h01, {3'h0, protocol_state});
		rst <= 1'b0;
		wait_idle();
		$display("second reset test done");
		reader.send('{8'h26, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0}, 1, 1'b0, 1'b0, -1);
		expect_reply(2, 24'h000044, 1'b0, SD, SD + 60);
		uid_match <= 1'b0;
		write_case('{8'h93, 8'h70, 32'h0, 4'h5, 2'h0, 1'b0, 8'hff, 5'h02});
		uid_match <= 1'b1;
		$display("select mismatch test done");
		summarize();
	end
endmodule
